// ### common/sfr_pkg.sv
// Operation
// - Each frame starts after at least one idle symbol, the start marker.
// - Every idle symbol clears the partial frame and restarts at the tag, unless it closes an acknowledged frame.
// - Tag zero sends the payload to the output code word.
// - Tag one sends the frame to a configuration register.
// - Sixteen payload symbols follow the tag and form one code word.
// - Configuration payload: first byte is address, second byte is data.
// - Payload is sent and assembled most significant bit first.
// - High slice parity covers tag plus first payload byte, nine symbols.
// - Low slice parity covers only the second payload byte.
// - Parity symbol is one for an even count of ones, zero for odd.
// - An idle symbol after both parity symbols completes a valid frame.
// - Optional acknowledge follows the closing idle symbol directly.
// - Acknowledge lasts twice the measured low slice parity symbol.
// - Each symbol is judged alone on its period limits and duty cycle.
// - Reverse direction carries only the acknowledge pulse.
// - On a fault the output goes to the band chosen by the band pin.
// - Fault level comes from the low or high fault current register.
// - Zero is 25 percent high, one 75 percent, idle 50 percent.
// - During acknowledge the device closes its path switch and drives.
// - Fault flag rises when link activity stops, unless checking is off.
package sfr_pkg;
  // Clock rate and symbol timing.
  localparam int CLK_MHZ          = 250;
  localparam int TP_MIN_NS        = 1000;
  localparam int TP_MAX_NS        = 100000;
  localparam int LINK_TIMEOUT_NS  = 1000000;
  localparam int TP_MIN_CYC       = (TP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int TP_MAX_CYC       = (TP_MAX_NS * CLK_MHZ) / 1000;
  localparam int LINK_TIMEOUT_CYC = (LINK_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int ACK_TAIL_CYC     = 3;
  localparam int PAYLOAD_BITS     = 16;
  // Duty windows in sixteenths of the symbol period; gaps are noise margins.
  localparam int ZERO_LO = 2;
  localparam int ZERO_HI = 6;
  localparam int IDLE_LO = 7;
  localparam int IDLE_HI = 9;
  localparam int ONE_LO  = 10;
  localparam int ONE_HI  = 14;
  // Register addresses and reset values.
  localparam logic [7:0]  ADDR_CONFIG = 8'h02;
  localparam logic [7:0]  ADDR_LOW    = 8'h04;
  localparam logic [7:0]  ADDR_HIGH   = 8'h05;
  localparam logic [7:0]  CONFIG_RST  = 8'h1f;
  localparam logic [7:0]  LOW_RST     = 8'h24;
  localparam logic [7:0]  HIGH_RST    = 8'he8;
  localparam logic [15:0] CODE_RST    = 16'h0000;
  // Configuration register fields.
  localparam int CFG_LINK_CHECK_BIT = 0;
  localparam int CFG_ACK_EN_BIT     = 1;
  // Decoded symbol kinds.
  typedef enum logic [1:0] {
    SFR_SYM_ZERO = 2'h0,
    SFR_SYM_ONE  = 2'h1,
    SFR_SYM_IDLE = 2'h2,
    SFR_SYM_BAD  = 2'h3
  } sfr_sym_e;
  // Frame receiver states.
  typedef enum logic [6:0] {
    ST_HUNT = 7'h01,
    ST_TAG  = 7'h02,
    ST_DATA = 7'h04,
    ST_PHI  = 7'h08,
    ST_PLO  = 7'h10,
    ST_END  = 7'h20,
    ST_ACK  = 7'h40
  } sfr_state_e;
endpackage

// ### common/sfr_sym_if.sv
// Symbol stream from the measurement stage to the frame logic.
interface sfr_sym_if;
  logic               sym_valid;
  logic               sym_gap;
  sfr_pkg::sfr_sym_e  sym_code;
  logic [15:0]        sym_period;
  logic               expect_idle;
  logic               hold;
  modport meas  (input expect_idle, input hold, output sym_valid, output sym_gap, output sym_code, output sym_period);
  modport frame (output expect_idle, output hold, input sym_valid, input sym_gap, input sym_code, input sym_period);
endinterface

// ### hdl/sfr_sym_meas.sv
module sfr_sym_meas #(
  parameter int TP_MAX_CYC = sfr_pkg::TP_MAX_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  input  wire logic line_i,
  sfr_sym_if.meas   sym_if
);
  localparam logic [16:0] TP_MAX_W = TP_MAX_CYC[16:0];
  localparam logic [16:0] TP_MIN_W = sfr_pkg::TP_MIN_CYC[16:0];

  logic        line_q;
  logic [15:0] high_cnt;
  logic [15:0] low_cnt;
  logic        armed;
  logic [16:0] sum_cnt;
  logic [16:0] meas_period;
  logic        rise;
  logic        timeout;
  logic        early;
  logic        emit;

  // Classifies one symbol from its own period and high time only.
  function automatic sfr_pkg::sfr_sym_e classify(input logic [16:0] p, input logic [15:0] h);
    logic [21:0] h16;
    logic [21:0] pw;
    h16 = {2'h0, h, 4'h0};
    pw  = {5'h00, p};
    if (p < TP_MIN_W || p > TP_MAX_W) begin
      classify = sfr_pkg::SFR_SYM_BAD;
    end else if (h16 > pw * 22'(sfr_pkg::ZERO_LO) && h16 < pw * 22'(sfr_pkg::ZERO_HI)) begin
      classify = sfr_pkg::SFR_SYM_ZERO;
    end else if (h16 > pw * 22'(sfr_pkg::IDLE_LO) && h16 < pw * 22'(sfr_pkg::IDLE_HI)) begin
      classify = sfr_pkg::SFR_SYM_IDLE;
    end else if (h16 > pw * 22'(sfr_pkg::ONE_LO) && h16 < pw * 22'(sfr_pkg::ONE_HI)) begin
      classify = sfr_pkg::SFR_SYM_ONE;
    end else begin
      classify = sfr_pkg::SFR_SYM_BAD;
    end
  endfunction

  // A symbol closes at the next rising edge; a closing idle closes once low equals high.
  assign rise        = line_i & ~line_q;
  assign sum_cnt     = {1'b0, high_cnt} + {1'b0, low_cnt};
  assign timeout     = armed & ~line_i & (sum_cnt >= TP_MAX_W);
  assign early       = armed & ~line_i & sym_if.expect_idle & (low_cnt == high_cnt) & (high_cnt != 16'h0000);
  assign emit        = armed & (rise | early) & ~sym_if.hold;
  assign meas_period = early ? {high_cnt, 1'b0} : sum_cnt;

  // High and low time counters, restarted by every rising edge.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_q   <= 1'b0;
      high_cnt <= 16'h0000;
      low_cnt  <= 16'h0000;
      armed    <= 1'b0;
    end else if (ce_i) begin
      line_q <= line_i;
      if (sym_if.hold) begin
        high_cnt <= 16'h0000;
        low_cnt  <= 16'h0000;
        armed    <= 1'b0;
      end else if (rise) begin
        high_cnt <= 16'h0001;
        low_cnt  <= 16'h0000;
        armed    <= 1'b1;
      end else if (early || timeout) begin
        high_cnt <= 16'h0000;
        low_cnt  <= 16'h0000;
        armed    <= 1'b0;
      end else if (armed && line_i && high_cnt != 16'hffff) begin
        high_cnt <= high_cnt + 16'h0001;
      end else if (armed && !line_i && low_cnt != 16'hffff) begin
        low_cnt <= low_cnt + 16'h0001;
      end
    end
  end

  // Registered symbol stream; a long low stretch is reported as a gap.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sym_if.sym_valid  <= 1'b0;
      sym_if.sym_gap    <= 1'b0;
      sym_if.sym_code   <= sfr_pkg::SFR_SYM_BAD;
      sym_if.sym_period <= 16'h0000;
    end else if (ce_i) begin
      sym_if.sym_valid <= emit;
      sym_if.sym_gap   <= timeout & ~sym_if.hold & ~early;
      if (emit) begin
        sym_if.sym_code   <= classify(meas_period, high_cnt);
        sym_if.sym_period <= meas_period[16] ? 16'hffff : meas_period[15:0];
      end
    end
  end
endmodule

// ### hdl/sfr_frame_rx.sv
module sfr_frame_rx #(
  parameter int TP_MAX_CYC       = sfr_pkg::TP_MAX_CYC,
  parameter int LINK_TIMEOUT_CYC = sfr_pkg::LINK_TIMEOUT_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        single_wire_port_i,
  output logic             single_wire_port_o,
  output logic             single_wire_port_oe_n_o,
  output logic             ack_path_switch_n_o,
  input  wire logic        error_band_select_pin_i,
  output logic [15:0]      output_code_word_o,
  output logic             fault_flag_out_n_o,
  output logic [7:0]       fault_level_o
);
  localparam logic [23:0] LINK_LIMIT = LINK_TIMEOUT_CYC[23:0];
  localparam logic [3:0]  LAST_BIT   = 4'(sfr_pkg::PAYLOAD_BITS - 1);
  localparam logic [17:0] ACK_TAIL   = 18'(sfr_pkg::ACK_TAIL_CYC);

  sfr_sym_if sym_bus();

  logic [1:0]           sync_a;
  logic [1:0]           sync_b;
  logic                 line_s;
  logic                 band_s;
  sfr_pkg::sfr_state_e  state;
  sfr_pkg::sfr_state_e  next_state;
  logic                 tag;
  logic [15:0]          shift;
  logic [3:0]           bit_cnt;
  logic                 p_hi;
  logic                 p_lo;
  logic [15:0]          p0_period;
  logic [7:0]           config_reg;
  logic [7:0]           low_level;
  logic [7:0]           high_level;
  logic [17:0]          ack_cnt;
  logic [17:0]          ack_len;
  logic                 ack_drive;
  logic [23:0]          act_cnt;
  logic                 is_bit;
  logic                 bit_val;
  logic                 is_idle;
  logic                 hi_ok;
  logic                 lo_ok;
  logic                 frame_end;
  logic                 commit;
  logic                 ack_go;

  // Two-stage synchronisers for the link pin and the band select pin.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end else if (ce_i) begin
      sync_a <= {error_band_select_pin_i, single_wire_port_i};
      sync_b <= sync_a;
    end
  end

  assign line_s = sync_b[0];
  assign band_s = sync_b[1];

  // Symbol measurement stage.
  sfr_sym_meas #(
    .TP_MAX_CYC (TP_MAX_CYC)
  ) u_meas (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .line_i     (line_s),
    .sym_if     (sym_bus)
  );

  // Feedback to the measurement stage: early idle close and our own drive ignored.
  assign sym_bus.expect_idle = (state == sfr_pkg::ST_END);
  assign sym_bus.hold        = (state == sfr_pkg::ST_ACK);

  // Symbol decode and parity checks; parity is one for an even count of ones.
  assign is_idle   = sym_bus.sym_valid & (sym_bus.sym_code == sfr_pkg::SFR_SYM_IDLE);
  assign is_bit    = sym_bus.sym_valid & ((sym_bus.sym_code == sfr_pkg::SFR_SYM_ZERO) |
                                          (sym_bus.sym_code == sfr_pkg::SFR_SYM_ONE));
  assign bit_val   = (sym_bus.sym_code == sfr_pkg::SFR_SYM_ONE);
  assign hi_ok     = (p_hi == ~^{tag, shift[15:8]});
  assign lo_ok     = (p_lo == ~^shift[7:0]);
  assign frame_end = is_idle & (state == sfr_pkg::ST_END);
  assign commit    = frame_end & hi_ok & lo_ok;
  assign ack_go    = commit & config_reg[sfr_pkg::CFG_ACK_EN_BIT];

  // Next state of the frame sequencer.
  always_comb begin
    next_state = state;
    case (state)
      sfr_pkg::ST_ACK: begin
        if (ack_cnt >= ack_len + ACK_TAIL) begin
          next_state = sfr_pkg::ST_HUNT;
        end
      end
      sfr_pkg::ST_HUNT, sfr_pkg::ST_TAG, sfr_pkg::ST_DATA, sfr_pkg::ST_PHI,
      sfr_pkg::ST_PLO, sfr_pkg::ST_END: begin
        if (sym_bus.sym_gap) begin
          next_state = sfr_pkg::ST_HUNT;
        end else if (frame_end) begin
          next_state = ack_go ? sfr_pkg::ST_ACK : sfr_pkg::ST_TAG;
        end else if (is_idle) begin
          next_state = sfr_pkg::ST_TAG;
        end else if (sym_bus.sym_valid && !is_bit) begin
          next_state = sfr_pkg::ST_HUNT;
        end else if (is_bit) begin
          case (state)
            sfr_pkg::ST_HUNT: next_state = sfr_pkg::ST_HUNT;
            sfr_pkg::ST_TAG:  next_state = sfr_pkg::ST_DATA;
            sfr_pkg::ST_DATA: next_state = (bit_cnt == LAST_BIT) ? sfr_pkg::ST_PHI : sfr_pkg::ST_DATA;
            sfr_pkg::ST_PHI:  next_state = sfr_pkg::ST_PLO;
            sfr_pkg::ST_PLO:  next_state = sfr_pkg::ST_END;
            default:          next_state = sfr_pkg::ST_HUNT;
          endcase
        end
      end
      default: begin
        next_state = sfr_pkg::ST_HUNT;
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= sfr_pkg::ST_HUNT;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Frame buffer: tag, payload shifted in from the bottom, parity symbols.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tag       <= 1'b0;
      shift     <= 16'h0000;
      bit_cnt   <= 4'h0;
      p_hi      <= 1'b0;
      p_lo      <= 1'b0;
      p0_period <= 16'h0000;
    end else if (ce_i && state != sfr_pkg::ST_ACK) begin
      if (is_idle && state != sfr_pkg::ST_END) begin
        tag     <= 1'b0;
        shift   <= 16'h0000;
        bit_cnt <= 4'h0;
      end else if (is_bit && state == sfr_pkg::ST_TAG) begin
        tag <= bit_val;
      end else if (is_bit && state == sfr_pkg::ST_DATA) begin
        shift   <= {shift[14:0], bit_val};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (is_bit && state == sfr_pkg::ST_PHI) begin
        p_hi <= bit_val;
      end else if (is_bit && state == sfr_pkg::ST_PLO) begin
        p_lo      <= bit_val;
        p0_period <= sym_bus.sym_period;
      end else if (frame_end) begin
        bit_cnt <= 4'h0;
        shift   <= 16'h0000;
        tag     <= 1'b0;
      end
    end
  end

  // Output code word and configuration registers, written only by a good frame.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      output_code_word_o <= sfr_pkg::CODE_RST;
      config_reg         <= sfr_pkg::CONFIG_RST;
      low_level          <= sfr_pkg::LOW_RST;
      high_level         <= sfr_pkg::HIGH_RST;
    end else if (ce_i && commit) begin
      if (!tag) begin
        output_code_word_o <= shift;
      end else begin
        case (shift[15:8])
          sfr_pkg::ADDR_CONFIG: config_reg <= shift[7:0];
          sfr_pkg::ADDR_LOW:    low_level  <= shift[7:0];
          sfr_pkg::ADDR_HIGH:   high_level <= shift[7:0];
          default:              config_reg <= config_reg;
        endcase
      end
    end
  end

  // Acknowledge pulse: drive the line high for twice the low parity period.
  assign ack_len = {1'b0, p0_period, 1'b0};

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_cnt   <= 18'h0_0000;
      ack_drive <= 1'b0;
    end else if (ce_i) begin
      if (ack_go) begin
        ack_cnt   <= 18'h0_0001;
        ack_drive <= 1'b1;
      end else if (state == sfr_pkg::ST_ACK) begin
        ack_cnt   <= ack_cnt + 18'h0_0001;
        ack_drive <= (ack_cnt < ack_len);
      end else begin
        ack_cnt   <= 18'h0_0000;
        ack_drive <= 1'b0;
      end
    end
  end

  // The line is driven only while the acknowledge pulse is out.
  assign single_wire_port_o      = ack_drive;
  assign single_wire_port_oe_n_o = ~ack_drive;
  assign ack_path_switch_n_o     = ~(state == sfr_pkg::ST_ACK);

  // Link activity watchdog and fault band selection.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_cnt            <= 24'h00_0000;
      fault_flag_out_n_o <= 1'b1;
      fault_level_o      <= sfr_pkg::LOW_RST;
    end else if (ce_i) begin
      if (sym_bus.sym_valid) begin
        act_cnt <= 24'h00_0000;
      end else if (act_cnt < LINK_LIMIT) begin
        act_cnt <= act_cnt + 24'h00_0001;
      end
      fault_flag_out_n_o <= ~(config_reg[sfr_pkg::CFG_LINK_CHECK_BIT] && act_cnt >= LINK_LIMIT);
      fault_level_o      <= band_s ? high_level : low_level;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Checks on the frame sequencer and outputs.
  a_idle_restart: assert property (ce_i && is_idle && state != sfr_pkg::ST_END && state != sfr_pkg::ST_ACK
    |=> state == sfr_pkg::ST_TAG && bit_cnt == 4'h0 && shift == 16'h0000)
    else $error("idle symbol did not restart the frame");
  a_code_route: assert property (ce_i && commit && !tag |=> output_code_word_o == $past(shift))
    else $error("code frame did not load the output code word");
  a_cfg_route: assert property (ce_i && commit && tag |=> $stable(output_code_word_o))
    else $error("configuration frame changed the output code word");
  a_cfg_low_write: assert property (ce_i && commit && tag && shift[15:8] == sfr_pkg::ADDR_LOW
    |=> low_level == $past(shift[7:0]))
    else $error("low fault level not written");
  a_msb_first: assert property (ce_i && is_bit && state == sfr_pkg::ST_DATA
    |=> shift[0] == $past(bit_val) && shift[15:1] == $past(shift[14:0]))
    else $error("payload not shifted most significant bit first");
  a_parity_reject: assert property (ce_i && frame_end && !(hi_ok && lo_ok)
    |=> $stable(output_code_word_o) && $stable(low_level) && $stable(high_level) && !ack_drive)
    else $error("bad frame updated a register or was acknowledged");
  a_ack_start: assert property ($rose(ack_drive) |-> $past(state) == sfr_pkg::ST_END && ack_cnt == 18'h0_0001)
    else $error("acknowledge did not follow the closing idle");
  a_ack_length: assert property ($fell(ack_drive) |-> ack_cnt == ack_len + 18'h0_0001)
    else $error("acknowledge length is not twice the low parity period");
  a_drive_only_ack: assert property (!single_wire_port_oe_n_o |-> state == sfr_pkg::ST_ACK && !ack_path_switch_n_o)
    else $error("line driven outside the acknowledge");
  a_fault_band: assert property (ce_i |=> fault_level_o == ($past(band_s) ? $past(high_level) : $past(low_level)))
    else $error("fault level does not follow the band select");
  a_link_fault: assert property (ce_i && config_reg[sfr_pkg::CFG_LINK_CHECK_BIT] && act_cnt >= LINK_LIMIT
    |=> !fault_flag_out_n_o)
    else $error("fault flag not raised after link inactivity");

  c_code_frame: cover property (ce_i && commit && !tag);
  c_cfg_frame: cover property (ce_i && commit && tag);
  c_ack_sent: cover property ($fell(ack_drive));
  c_parity_bad: cover property (ce_i && frame_end && !(hi_ok && lo_ok));
endmodule

// ### tb/sfr_master_model.sv
module sfr_master_model (
  input  wire logic core_clk_i,
  input  wire logic dev_drive_i,
  input  wire logic dev_oe_n_i,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PER    = 256;
  localparam int PER_P0 = 320;
  logic lvl  = 1'b0;
  logic en   = 1'b1;
  logic last = 1'b0;
  // The device wins while it drives; a released line shows the inverse of its last level.
  assign line_o = !dev_oe_n_i ? dev_drive_i : (en ? lvl : ~last);
  // Remember the previous wire level so a floating line keeps changing.
  always @(posedge core_clk_i) last <= line_o;
  // Step a number of edges, then settle just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // One symbol: high for hi cycles, then low until the period ends.
  task automatic sym(input int hi, input int per);
    lvl = 1'b1;
    tick(hi);
    lvl = 1'b0;
    tick(per - hi);
  endtask
  // A data symbol is a quarter or three quarters high.
  task automatic bit_sym(input logic b, input int per);
    sym(b ? per * 3 / 4 : per / 4, per);
  endtask
  // Always-low filler between frames.
  task automatic filler(input int n);
    lvl = 1'b0;
    tick(n);
  endtask
  // Whole frame; err 1 flips high parity, 2 sends a bad tag symbol, 3 stops after six payload bits.
  task automatic frame(input logic tag, input logic [15:0] pl, input int n_idle, input int err);
    logic p1;
    logic p0;
    int   i;
    int   k;
    p1 = ~^{tag, pl[15:8]};
    p0 = ~^pl[7:0];
    for (i = 0; i < n_idle; i++) sym(PER / 2, PER);
    if (err == 2) sym(PER / 16, PER);
    else bit_sym(tag, PER);
    for (i = 15; i >= 0; i--) begin
      if (err == 3 && i == 9) return;
      bit_sym(pl[i], PER + 32 * (i % 2));
    end
    bit_sym(p1 ^ (err == 1), PER);
    bit_sym(p0, PER_P0);
    lvl = 1'b1;
    tick(PER / 2);
    lvl = 1'b0;
    tick(PER / 2 + 8);
    // Let go of the line and listen while the device answers.
    if (err == 0) begin
      en = 1'b0;
      for (k = 0; k < 40 && dev_oe_n_i; k++) tick(1);
      for (k = 0; k < 2000 && !dev_oe_n_i; k++) tick(1);
      en = 1'b1;
      // Stay low until the device has left its acknowledge tail, so the next rise is seen.
      tick(16);
    end
  endtask
endmodule

// ### tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk_i = 1'b0;
  logic        rstn_i     = 1'b0;
  logic        ce         = 1'b1;
  logic        band       = 1'b0;
  logic        line;
  logic        port_o;
  logic        oe_n;
  logic        sw_n;
  logic        fault_n;
  logic [15:0] code;
  logic [7:0]  level;
  int          n_fail     = 0;
  int          compares   = 0;
  int          seed       = 32'h18d8;
  int          ack_q[$];
  logic [15:0] code_q[$];
  int          ack_len    = 0;
  logic [15:0] code_prev  = 16'h0000;
  logic [7:0]  lo_v       = 8'h24;
  logic [7:0]  hi_v       = 8'he8;
  logic [15:0] pl;
  // Free running 250 MHz clock.
  initial forever #2 core_clk_i = ~core_clk_i;
  sfr_frame_rx #(
    .TP_MAX_CYC       (2000),
    .LINK_TIMEOUT_CYC (5000)
  ) u_sfr_frame_rx (
    .core_clk_i              (core_clk_i),
    .rstn_i                  (rstn_i),
    .ce_i                    (ce),
    .single_wire_port_i      (line),
    .single_wire_port_o      (port_o),
    .single_wire_port_oe_n_o (oe_n),
    .ack_path_switch_n_o     (sw_n),
    .error_band_select_pin_i (band),
    .output_code_word_o      (code),
    .fault_flag_out_n_o      (fault_n),
    .fault_level_o           (level)
  );
  sfr_master_model u_sfr_master_model (
    .core_clk_i  (core_clk_i),
    .dev_drive_i (port_o),
    .dev_oe_n_i  (oe_n),
    .line_o      (line)
  );
  // Compare one value and report a difference at once.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Send a frame and note the acknowledge length it must earn.
  task automatic send(input logic tag, input logic [15:0] p, input int n_idle, input int err, input int exp_ack);
    if (exp_ack != 0) ack_q.push_back(2 * 320);
    u_sfr_master_model.frame(tag, p, n_idle, err);
  endtask
  // Watch acknowledge pulses and code word updates against the oldest notes.
  always @(posedge core_clk_i) begin
    if (port_o === 1'b1) begin
      ack_len++;
      if (ack_len == 1) begin
        check("ack_oe_n", 0, oe_n);
        check("ack_switch_n", 0, sw_n);
      end
    end else if (ack_len != 0) begin
      if (ack_q.size() == 0) check("ack_unexpected", 0, ack_len);
      else check("ack_len", ack_q.pop_front(), ack_len);
      ack_len = 0;
    end
    if (code !== code_prev) begin
      if (code_q.size() == 0) check("code_unexpected", code_prev, code);
      else check("code", code_q.pop_front(), code);
      code_prev = code;
    end
  end
  // Hang guard.
  initial begin
    repeat (100000) @(posedge core_clk_i);
    n_fail++;
    test_done();
  end
  // Main sequence.
  initial begin
    int e;
    repeat (4) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    check("rst_code", 16'h0000, code);
    check("rst_fault_n", 1, fault_n);
    check("rst_port_o", 0, port_o);
    check("rst_oe_n", 1, oe_n);
    check("rst_switch_n", 1, sw_n);
    check("rst_level_low", 8'h24, level);
    // A low clock enable freezes the band synchroniser and the level register.
    ce   = 1'b0;
    band = 1'b1;
    u_sfr_master_model.tick(5);
    check("ce_freeze_level", 8'h24, level);
    ce = 1'b1;
    u_sfr_master_model.tick(5);
    check("rst_level_high", 8'he8, level);
    band = 1'b0;
    u_sfr_master_model.tick(5);
    // Code frame after several start idles.
    pl = 16'($random(seed));
    code_q.push_back(pl);
    send(1'b0, pl, 3, 0, 1);
    // Bad parity, bad symbol and a truncated frame change nothing.
    for (e = 1; e <= 3; e++) send(1'b0, 16'($random(seed)), 1, e, 0);
    pl = 16'($random(seed));
    code_q.push_back(pl);
    send(1'b0, pl, 1, 0, 1);
    // Configuration writes to both fault levels, then band selection.
    hi_v = 8'($random(seed));
    send(1'b1, {8'h05, hi_v}, 1, 0, 1);
    lo_v = 8'($random(seed));
    send(1'b1, {8'h04, lo_v}, 1, 0, 1);
    band = 1'b1;
    u_sfr_master_model.tick(5);
    check("level_high", hi_v, level);
    band = 1'b0;
    u_sfr_master_model.tick(5);
    check("level_low", lo_v, level);
    // Unmapped address is ignored, but the good frame is still acknowledged.
    send(1'b1, {8'h03, ~lo_v}, 1, 0, 1);
    check("level_unmapped", lo_v, level);
    // Link inactivity with checking off, then on.
    send(1'b1, {8'h02, 8'h1e}, 1, 0, 1);
    u_sfr_master_model.filler(5600);
    check("fault_check_off", 1, fault_n);
    send(1'b1, {8'h02, 8'h1f}, 1, 0, 1);
    u_sfr_master_model.filler(5600);
    check("fault_check_on", 0, fault_n);
    u_sfr_master_model.sym(128, 256);
    u_sfr_master_model.sym(128, 256);
    u_sfr_master_model.tick(4);
    check("fault_cleared", 1, fault_n);
    check("ack_left", 0, ack_q.size());
    check("code_left", 0, code_q.size());
    test_done();
  end
endmodule
